// ===== hdl/adcpc_pkg.sv
// Package: constants, states and carriers of the ADC pin control block
package adcpc_pkg;

    // ========================================================
    // Clock and timing
    localparam int CORE_CLK_HZ = 40000000;
    localparam int CLK_PERIOD_NS = 25;
    // Nominal master clock: fast and low-power variants
    localparam int MCLK_FAST_HZ = 4000000;
    localparam int MCLK_LOW_HZ = 1800000;
    // Conversion and calibration length in master clock periods
    localparam logic [7:0] CONV_MCLK_CYCLES = 8'h14;
    localparam logic [7:0] CAL_MCLK_CYCLES = 8'h78;
    // Self-clocked serial clock half period, least time
    localparam int SCLK_HALF_NS = 100;
    localparam int SCLK_HALF_CYC =
        (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0] DIV_LAST = 3'(SCLK_HALF_CYC - 1);

    // ========================================================
    // Pin synchroniser bit positions
    localparam int NUM_SYNC = 11;
    localparam int I_TRIG = 0;
    localparam int I_CAL = 1;
    localparam int I_SLEEP = 2;
    localparam int I_RANGE = 3;
    localparam int I_POL = 4;
    localparam int I_SMA = 5;
    localparam int I_SMB = 6;
    localparam int I_MCLK = 7;
    localparam int I_SCLK = 8;
    localparam int I_DIN = 9;
    localparam int I_SYNC = 10;
    // Trigger idles high, calibration seen low so power-up calibrates
    localparam logic [NUM_SYNC-1:0] PIN_RST = 11'h405;

    // ========================================================
    // Serial word layout
    localparam logic [3:0] FRAME_LAST = 4'hF;
    localparam int TGT_B1 = 15;
    localparam int TGT_B0 = 14;
    localparam logic [1:0] TGT_NONE = 2'h0;
    localparam logic [1:0] TGT_TEST = 2'h1;
    localparam logic [1:0] TGT_CAL = 2'h2;
    localparam logic [1:0] TGT_CTRL = 2'h3;
    localparam int RDSEL_LSB = 6;
    localparam logic [1:0] RD_RESULT = 2'h0;
    localparam logic [1:0] RD_TEST = 2'h1;
    localparam logic [1:0] RD_CAL = 2'h2;
    localparam logic [13:0] CTRL_WORD_RST = 14'h0000;

    // ========================================================
    // APB register map
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_STATUS = 8'h04;
    localparam logic [7:0] A_IRQ_STAT = 8'h08;
    localparam logic [7:0] A_IRQ_MASK = 8'h0C;
    localparam logic [7:0] A_RESULT = 8'h10;
    localparam logic [7:0] A_SER_CTRL = 8'h14;
    localparam int B_SOFT_START = 0;
    localparam int B_AUTO_EN = 1;
    localparam logic AUTO_EN_RST = 1'b1;
    localparam logic [3:0] IRQ_MASK_RST = 4'h0;
    localparam int EV_CONV = 0;
    localparam int EV_CAL = 1;
    localparam int EV_WRITE = 2;
    localparam int EV_FRAME = 3;

    // ========================================================
    // States and carriers
    typedef enum logic [2:0] {
        ST_IDLE, ST_ARMED, ST_CONV, ST_CAL_HELD, ST_CAL_RUN
    } adcpc_state_t;

    typedef enum logic {SER_IDLE, SER_SHIFT} adcpc_ser_t;

    typedef struct packed {
        logic self_clk;
        logic bidir;
        logic cs_mode;
    } adcpc_mode_t;

    typedef struct packed {
        logic [NUM_SYNC-1:0] meta;
        logic [NUM_SYNC-1:0] sync;
        logic [NUM_SYNC-1:0] prev;
        adcpc_state_t st;
        logic busy;
        logic hold;
        logic pwrdn;
        logic range_bip;
        logic [7:0] mcnt;
        logic [11:0] result;
        logic [13:0] ctrl_word;
        logic [13:0] test_word;
        logic [13:0] cal_word;
        adcpc_ser_t ser;
        logic [3:0] bitcnt;
        logic [15:0] tx;
        logic [15:0] rx;
        logic [2:0] divcnt;
        logic sclk_o;
        logic dout;
        logic sync_o;
        logic auto_en;
        logic [3:0] irq_stat;
        logic [3:0] irq_mask;
        logic irq;
        logic [31:0] prdata;
    } adcpc_regs_t;

endpackage

// ===== hdl/adcpc_top.sv
// ADC pin control, conversion sequencer, serial port and APB registers
`timescale 1ns/1ps

// How it works
// RULE_01 - Trigger rise puts track-and-hold into hold and starts conversion.
// RULE_02 - Busy rises on trigger fall or calibration rise; falls when done.
// RULE_03 - Busy also marks the end of the calibration sequence.
// RULE_04 - Sleep low powers down unless converting or calibrating; cal kept.
// RULE_05 - Range select low gives unipolar span, high gives bipolar span.
// RULE_06 - Polarity sets serial clock idle level and so its active edge.
// RULE_07 - Two mode select pins together choose the serial mode.
// RULE_08 - Cal input low resets cal logic; its rising edge starts calibration.
// RULE_09 - Calibration input overrides every other operation in progress; the code aborts a conversion but lets a serial frame run on and latch.
// RULE_10 - Read data leaves on the serial output as one 16-bit word.
// RULE_11 - Host sends write data as one 16-bit word per write.
// RULE_12 - Data input pin is input-only or bidirectional depending on mode.
// RULE_13 - Master clock sets conversion and calibration durations.
// RULE_14 - Serial clock is output when self-clocked, input otherwise.
// RULE_15 - Sync pin is active-low level input or frame sync output, per mode.
// RULE_16 - End of conversion returns track-and-hold to track mode.
// RULE_17 - Top two write bits pick target; data latched after all 16 bits.
// RULE_18 - Result reads carry four leading zeros ahead of twelve bits.
module adcpc_top
    import adcpc_pkg::*;
(
    input wire logic CORE_CLK_IN, // Core clock, 40 MHz
    input wire logic SRST_IN, // Synchronous reset, active high
    input wire logic CONVERSION_TRIGGER_IN, // Conversion trigger pin
    input wire logic CAL_N_IN, // Calibration pin, low resets
    input wire logic SLEEP_N_IN, // Sleep pin, low sleeps
    input wire logic INPUT_RANGE_SELECT_IN, // Analog span select pin
    input wire logic POLARITY_IN, // Serial clock idle level pin
    input wire logic SERIAL_MODE_SEL_A_IN, // Serial mode select a
    input wire logic SERIAL_MODE_SEL_B_IN, // Serial mode select b
    input wire logic MASTER_CLOCK_IN, // Master clock pin
    input wire logic [11:0] ADC_CODE_IN, // Code from converter core
    input wire logic SCLK_IN, // Serial clock pin, input side
    output logic SCLK_OUT, // Serial clock pin, output side
    output logic SCLK_OE_N_OUT, // Serial clock drive, low drives
    input wire logic DIN_IN, // Data input pin, input side
    output logic DIN_OUT, // Data input pin, output side
    output logic DIN_OE_N_OUT, // Data input pin drive, low drives
    output logic DOUT_OUT, // Serial data output pin
    input wire logic SYNC_N_IN, // Sync pin, input side
    output logic SYNC_N_OUT, // Sync pin, output side
    output logic SYNC_OE_N_OUT, // Sync pin drive, low drives
    output logic BUSY_OUT, // Busy pin
    output logic HOLD_OUT, // Track-and-hold in hold
    output logic PWRDN_OUT, // Analog power down request
    output logic RANGE_BIPOLAR_OUT, // Bipolar span selected
    input wire logic PSEL_IN, // APB select
    input wire logic PENABLE_IN, // APB enable
    input wire logic PWRITE_IN, // APB direction
    input wire logic [7:0] PADDR_IN, // APB byte address
    input wire logic [31:0] PWDATA_IN, // APB write data
    output logic [31:0] PRDATA_OUT, // APB read data
    output logic PREADY_OUT, // APB ready
    output logic PSLVERR_OUT, // APB error, unmapped address
    output logic IRQ_OUT // Interrupt, level, active high
);

    // ========================================================
    // State
    adcpc_regs_t r_ff;
    adcpc_regs_t nxt_r;
    adcpc_mode_t mode;
    logic [NUM_SYNC-1:0] pins_raw;
    logic trig_rise;
    logic trig_fall;
    logic cal_low;
    logic cal_rise;
    logic mclk_rise;
    logic idle_lvl;
    logic sclk_trail;
    logic frame_start;
    logic [15:0] rx_next;
    logic [15:0] read_word;
    logic [3:0] ev;
    logic apb_setup;
    logic apb_access;
    logic apb_hit;
    logic apb_wr;
    logic conv_done;

    // Gather the pins for the two-stage synchroniser
    assign pins_raw = {SYNC_N_IN, DIN_IN, SCLK_IN, MASTER_CLOCK_IN,
                       SERIAL_MODE_SEL_B_IN, SERIAL_MODE_SEL_A_IN,
                       POLARITY_IN, INPUT_RANGE_SELECT_IN, SLEEP_N_IN,
                       CAL_N_IN, CONVERSION_TRIGGER_IN};

    // ========================================================
    // Edge detection on synchronised pins only
    assign trig_rise = r_ff.sync[I_TRIG] & ~r_ff.prev[I_TRIG];
    assign trig_fall = ~r_ff.sync[I_TRIG] & r_ff.prev[I_TRIG];
    assign cal_low = ~r_ff.sync[I_CAL];
    assign cal_rise = r_ff.sync[I_CAL] & ~r_ff.prev[I_CAL];
    assign mclk_rise = r_ff.sync[I_MCLK] & ~r_ff.prev[I_MCLK];
    assign idle_lvl = r_ff.sync[I_POL]; // RULE_06

    // Serial mode from both select pins
    assign mode.self_clk = r_ff.sync[I_SMA]; // RULE_07
    assign mode.bidir = r_ff.sync[I_SMA] & r_ff.sync[I_SMB]; // RULE_07
    assign mode.cs_mode = ~r_ff.sync[I_SMA] & ~r_ff.sync[I_SMB];

    // APB phases; the slave never waits
    assign apb_setup = PSEL_IN & ~PENABLE_IN;
    assign apb_access = PSEL_IN & PENABLE_IN;
    assign apb_hit = (PADDR_IN == A_CTRL) || (PADDR_IN == A_STATUS) ||
                     (PADDR_IN == A_IRQ_STAT) || (PADDR_IN == A_IRQ_MASK) ||
                     (PADDR_IN == A_RESULT) || (PADDR_IN == A_SER_CTRL);
    assign apb_wr = apb_access & PWRITE_IN & apb_hit;

    // Word offered on each read frame, chosen by the control word
    always_comb begin
        unique case (r_ff.ctrl_word[RDSEL_LSB +: 2])
            RD_RESULT: read_word = {4'h0, r_ff.result}; // RULE_18
            RD_TEST: read_word = {2'h0, r_ff.test_word};
            RD_CAL: read_word = {2'h0, r_ff.cal_word};
            default: read_word = {8'h00, r_ff.busy, r_ff.hold, r_ff.pwrdn,
                                  r_ff.range_bip, r_ff.ser, r_ff.st};
        endcase
    end

    // ========================================================
    // Next-state logic
    always_comb begin
        nxt_r = r_ff;
        ev = 4'h0;
        conv_done = 1'b0;
        sclk_trail = 1'b0;
        frame_start = 1'b0;
        rx_next = {r_ff.rx[14:0], r_ff.sync[I_DIN]};

        // Synchroniser: first stage read only by the second
        nxt_r.meta = pins_raw;
        nxt_r.sync = r_ff.meta;
        nxt_r.prev = r_ff.sync;
        nxt_r.range_bip = r_ff.sync[I_RANGE]; // RULE_05

        // Conversion and calibration; calibration pin checked first
        if (cal_low) begin
            nxt_r.st = ST_CAL_HELD; // RULE_08 RULE_09
            nxt_r.busy = 1'b0;
            nxt_r.hold = 1'b0;
            nxt_r.mcnt = 8'h00;
        end else begin
            unique case (r_ff.st)
                ST_IDLE, ST_ARMED: begin
                    if (trig_rise ||
                        (apb_wr && PADDR_IN == A_CTRL &&
                         PWDATA_IN[B_SOFT_START])) begin
                        nxt_r.st = ST_CONV;
                        nxt_r.hold = 1'b1; // RULE_01
                        nxt_r.busy = 1'b1;
                        nxt_r.mcnt = 8'h00;
                    end else if (trig_fall && r_ff.st == ST_IDLE) begin
                        nxt_r.st = ST_ARMED;
                        nxt_r.busy = 1'b1; // RULE_02
                    end
                end
                ST_CONV: begin
                    // Length counted in master clock periods
                    if (mclk_rise) begin // RULE_13
                        if (r_ff.mcnt == CONV_MCLK_CYCLES - 8'h01) begin
                            nxt_r.st = ST_IDLE;
                            nxt_r.hold = 1'b0; // RULE_16
                            nxt_r.busy = 1'b0; // RULE_02
                            nxt_r.result = ADC_CODE_IN;
                            conv_done = 1'b1;
                            ev[EV_CONV] = 1'b1;
                        end else begin
                            nxt_r.mcnt = r_ff.mcnt + 8'h01;
                        end
                    end
                end
                ST_CAL_HELD: begin
                    if (cal_rise) begin
                        nxt_r.st = ST_CAL_RUN; // RULE_08
                        nxt_r.busy = 1'b1; // RULE_02
                        nxt_r.mcnt = 8'h00;
                    end
                end
                ST_CAL_RUN: begin
                    if (mclk_rise) begin // RULE_13
                        if (r_ff.mcnt == CAL_MCLK_CYCLES - 8'h01) begin
                            nxt_r.st = ST_IDLE;
                            nxt_r.busy = 1'b0; // RULE_03
                            ev[EV_CAL] = 1'b1;
                        end else begin
                            nxt_r.mcnt = r_ff.mcnt + 8'h01;
                        end
                    end
                end
            endcase
        end

        // Power down only when nothing is running; stored words stay
        nxt_r.pwrdn = ~r_ff.sync[I_SLEEP] && (r_ff.st == ST_IDLE); // RULE_04

        // Serial clock edges: own divider or the sampled pin
        if (mode.self_clk) begin
            if (r_ff.ser == SER_SHIFT) begin
                if (r_ff.divcnt == DIV_LAST) begin
                    nxt_r.divcnt = 3'h0;
                    nxt_r.sclk_o = ~r_ff.sclk_o;
                    sclk_trail = (r_ff.sclk_o != idle_lvl);
                end else begin
                    nxt_r.divcnt = r_ff.divcnt + 3'h1;
                end
            end else begin
                nxt_r.divcnt = 3'h0;
                nxt_r.sclk_o = idle_lvl; // RULE_06
            end
            frame_start = conv_done && r_ff.auto_en &&
                          (r_ff.ser == SER_IDLE);
        end else begin
            nxt_r.sclk_o = idle_lvl;
            nxt_r.divcnt = 3'h0;
            sclk_trail = (r_ff.sync[I_SCLK] != r_ff.prev[I_SCLK]) &&
                         (r_ff.sync[I_SCLK] == idle_lvl); // RULE_06
            frame_start = ~r_ff.sync[I_SYNC] && r_ff.prev[I_SYNC] &&
                          (r_ff.ser == SER_IDLE); // RULE_15
        end

        // Shift engine: one 16-bit word out per frame, and one in except in bidirectional mode
        unique case (r_ff.ser)
            SER_IDLE: begin
                nxt_r.sync_o = 1'b1;
                if (frame_start) begin
                    nxt_r.ser = SER_SHIFT;
                    nxt_r.tx = read_word; // RULE_10
                    nxt_r.dout = read_word[15];
                    nxt_r.bitcnt = 4'h0;
                    nxt_r.sync_o = 1'b0; // RULE_15
                end
            end
            SER_SHIFT: begin
                if (mode.cs_mode && r_ff.sync[I_SYNC]) begin
                    // Chip select lost mid-word: nothing is written
                    nxt_r.ser = SER_IDLE;
                    nxt_r.sync_o = 1'b1;
                end else if (sclk_trail) begin
                    nxt_r.rx = rx_next; // RULE_11
                    if (r_ff.bitcnt == FRAME_LAST) begin
                        nxt_r.ser = SER_IDLE;
                        nxt_r.sync_o = 1'b1;
                        ev[EV_FRAME] = 1'b1;
                        // Bidirectional frames only carry read data
                        if (!mode.bidir) begin
                            ev[EV_WRITE] =
                                ({rx_next[TGT_B1], rx_next[TGT_B0]} !=
                                 TGT_NONE);
                            unique case ({rx_next[TGT_B1],
                                          rx_next[TGT_B0]}) // RULE_17
                                TGT_TEST: nxt_r.test_word = rx_next[13:0];
                                TGT_CAL: nxt_r.cal_word = rx_next[13:0];
                                TGT_CTRL: nxt_r.ctrl_word = rx_next[13:0];
                                TGT_NONE: nxt_r.ctrl_word = r_ff.ctrl_word;
                            endcase
                        end
                    end else begin
                        nxt_r.bitcnt = r_ff.bitcnt + 4'h1;
                        nxt_r.tx = {r_ff.tx[14:0], 1'b0};
                        nxt_r.dout = r_ff.tx[14]; // RULE_10
                    end
                end
            end
        endcase

        // APB read data captured in the setup cycle
        if (apb_setup && !PWRITE_IN) begin
            unique case (PADDR_IN)
                A_CTRL: nxt_r.prdata = {30'h0, r_ff.auto_en, 1'b0};
                A_STATUS: nxt_r.prdata = {21'h0, mode, r_ff.ser,
                                          r_ff.st, r_ff.range_bip,
                                          r_ff.pwrdn, r_ff.hold,
                                          r_ff.busy};
                A_IRQ_STAT: nxt_r.prdata = {28'h0, r_ff.irq_stat};
                A_IRQ_MASK: nxt_r.prdata = {28'h0, r_ff.irq_mask};
                A_RESULT: nxt_r.prdata = {20'h0, r_ff.result};
                A_SER_CTRL: nxt_r.prdata = {18'h0, r_ff.ctrl_word};
                default: nxt_r.prdata = 32'h0;
            endcase
        end

        // APB writes; a new event beats a clear in the same cycle
        nxt_r.irq_stat = r_ff.irq_stat;
        if (apb_wr) begin
            unique case (PADDR_IN)
                A_CTRL: nxt_r.auto_en = PWDATA_IN[B_AUTO_EN];
                A_IRQ_STAT: nxt_r.irq_stat = r_ff.irq_stat &
                                             ~PWDATA_IN[3:0];
                A_IRQ_MASK: nxt_r.irq_mask = PWDATA_IN[3:0];
                default: nxt_r.auto_en = r_ff.auto_en;
            endcase
        end
        nxt_r.irq_stat = nxt_r.irq_stat | ev;
        nxt_r.irq = |(nxt_r.irq_stat & nxt_r.irq_mask);
    end

    // ========================================================
    // Registers
    always_ff @(posedge CORE_CLK_IN) begin
        if (SRST_IN) begin
            r_ff <= '0;
            r_ff.meta <= PIN_RST;
            r_ff.sync <= PIN_RST;
            r_ff.prev <= PIN_RST;
            r_ff.st <= ST_CAL_HELD;
            r_ff.ser <= SER_IDLE;
            r_ff.sync_o <= 1'b1;
            r_ff.ctrl_word <= CTRL_WORD_RST;
            r_ff.auto_en <= AUTO_EN_RST;
            r_ff.irq_mask <= IRQ_MASK_RST;
        end else begin
            r_ff <= nxt_r;
        end
    end

    // ========================================================
    // Outputs; drive enables are low while this end drives
    assign BUSY_OUT = r_ff.busy;
    assign HOLD_OUT = r_ff.hold;
    assign PWRDN_OUT = r_ff.pwrdn;
    assign RANGE_BIPOLAR_OUT = r_ff.range_bip;
    assign SCLK_OUT = r_ff.sclk_o;
    assign SCLK_OE_N_OUT = ~mode.self_clk; // RULE_14
    assign SYNC_N_OUT = r_ff.sync_o;
    assign SYNC_OE_N_OUT = ~mode.self_clk; // RULE_15
    assign DOUT_OUT = r_ff.dout;
    assign DIN_OUT = r_ff.dout;
    assign DIN_OE_N_OUT = ~(mode.bidir && r_ff.ser == SER_SHIFT); // RULE_12
    assign PRDATA_OUT = r_ff.prdata;
    assign PREADY_OUT = 1'b1;
    assign PSLVERR_OUT = apb_access & ~apb_hit;
    assign IRQ_OUT = r_ff.irq;

    // ========================================================
    // Assertions
    default clocking cb @(posedge CORE_CLK_IN); endclocking
    default disable iff (SRST_IN);

    sequence s_conv_end;
        r_ff.st == ST_CONV && mclk_rise && !cal_low &&
        r_ff.mcnt == CONV_MCLK_CYCLES - 8'h01;
    endsequence

    sequence s_cal_start;
        r_ff.st == ST_CAL_HELD && cal_rise;
    endsequence

    a_hold_on_rise: assert property ( // RULE_01
        (r_ff.st == ST_IDLE || r_ff.st == ST_ARMED) && trig_rise &&
        !cal_low |=> HOLD_OUT && BUSY_OUT && r_ff.mcnt == 8'h00)
        else $error("hold not taken on trigger rise");

    a_busy_on_fall: assert property ( // RULE_02
        r_ff.st == ST_IDLE && trig_fall && !cal_low
        |=> BUSY_OUT && !HOLD_OUT)
        else $error("busy not raised on trigger fall");

    a_track_at_end: assert property ( // RULE_16
        s_conv_end |=> !HOLD_OUT && !BUSY_OUT &&
        r_ff.result == $past(ADC_CODE_IN))
        else $error("conversion end left hold or busy set");

    a_cal_busy_span: assert property ( // RULE_03
        s_cal_start ##1 (!cal_low)[*8] |-> BUSY_OUT)
        else $error("busy dropped early in calibration");

    a_cal_override: assert property ( // RULE_09
        cal_low |=> r_ff.st == ST_CAL_HELD && !BUSY_OUT && !HOLD_OUT)
        else $error("calibration pin low did not override");

    a_sleep_idle: assert property ( // RULE_04
        !r_ff.sync[I_SLEEP] && r_ff.st == ST_CONV |=> !PWRDN_OUT)
        else $error("powered down during conversion");

    a_lead_zeros: assert property ( // RULE_18
        frame_start && r_ff.ctrl_word[RDSEL_LSB +: 2] == RD_RESULT
        |=> r_ff.tx[15:12] == 4'h0 && DOUT_OUT == 1'b0)
        else $error("result word lacks leading zeros");

    a_ctrl_latch: assert property ( // RULE_17
        r_ff.ser == SER_SHIFT && sclk_trail && !mode.bidir &&
        r_ff.bitcnt == FRAME_LAST && rx_next[15:14] == TGT_CTRL &&
        !(mode.cs_mode && r_ff.sync[I_SYNC])
        |=> r_ff.ctrl_word == $past(rx_next[13:0]))
        else $error("control word not latched after 16 bits");

    a_sclk_idle: assert property ( // RULE_06
        mode.self_clk && r_ff.ser == SER_IDLE ##1
        mode.self_clk && r_ff.ser == SER_IDLE |-> SCLK_OUT == $past(idle_lvl))
        else $error("self clock not at idle level");

    a_sclk_dir: assert property ( // RULE_14
        SCLK_OE_N_OUT == !mode.self_clk && SYNC_OE_N_OUT == SCLK_OE_N_OUT)
        else $error("clock or sync direction wrong for mode");

endmodule

// ===== dv/adcpc_host.sv
// Host serial port model: external clock, chip select framing
`timescale 1ns/1ps
module adcpc_host (
    input wire logic clk, // Core clock
    input wire logic pol, // Clock idle level
    output logic sclk, // Serial clock to device
    output logic sync_n, // Chip select, active low
    output logic din, // Write data to device
    input wire logic dout // Read data from device
);
    // ========================================
    // Idle levels; clock stands still outside frames
    initial begin
        sclk = 1'b0;
        sync_n = 1'b1;
        din = 1'b0;
    end
    always @(posedge clk) begin
        if (sync_n) begin
            sclk <= pol;
        end
    end
    // One 16-bit frame, 200 ns clock; read sampled late in the
    // leading phase since device answers a few edges after detection
    task automatic frame(input logic [15:0] w, output logic [15:0] r);
        int i;
        sync_n <= 1'b0;
        repeat (4) @(posedge clk);
        for (i = 15; i >= 0; i--) begin
            sclk <= ~pol;
            din <= w[i];
            repeat (3) @(posedge clk);
            r[i] = dout;
            @(posedge clk);
            sclk <= pol;
            repeat (4) @(posedge clk);
        end
        repeat (4) @(posedge clk);
        sync_n <= 1'b1;
        din <= ~w[0]; // Released line shows no stale bit
        @(posedge clk);
    endtask
endmodule

// ===== dv/tb_adcpc_top.sv
// Testbench for the ADC pin control block
`timescale 1ns/1ps
module tb_adcpc_top import adcpc_pkg::*; ;
    logic clk = 0, rst = 1, trig = 1, cal_n = 1, slp_n = 1, rng = 0;
    logic pol = 0, mclk = 0, psel = 0, pen = 0, pwr = 0, sma = 0, smb = 0, e;
    logic [11:0] code = 12'h000;
    logic [7:0] pa = 8'h00;
    logic [31:0] pwd = 32'h0, pr, r;
    logic [15:0] r16;
    wire sclk, sync_n, din, dout;
    wire sclk_o, sclk_oe, din_o, din_oe, sync_o, sync_oe, busy, hold;
    wire pwrdn, bip, pready, pslverr, irq;
    int err_total = 0, check_count = 0, seed = 13, mc = 0, i, wn;
    adcpc_top i_dut (.CORE_CLK_IN(clk), .SRST_IN(rst),
        .CONVERSION_TRIGGER_IN(trig), .CAL_N_IN(cal_n),
        .SLEEP_N_IN(slp_n), .INPUT_RANGE_SELECT_IN(rng),
        .POLARITY_IN(pol), .SERIAL_MODE_SEL_A_IN(sma),
        .SERIAL_MODE_SEL_B_IN(smb), .MASTER_CLOCK_IN(mclk),
        .ADC_CODE_IN(code), .SCLK_IN(sclk), .SCLK_OUT(sclk_o),
        .SCLK_OE_N_OUT(sclk_oe), .DIN_IN(din), .DIN_OUT(din_o),
        .DIN_OE_N_OUT(din_oe), .DOUT_OUT(dout), .SYNC_N_IN(sync_n),
        .SYNC_N_OUT(sync_o), .SYNC_OE_N_OUT(sync_oe), .BUSY_OUT(busy),
        .HOLD_OUT(hold), .PWRDN_OUT(pwrdn), .RANGE_BIPOLAR_OUT(bip),
        .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
        .PADDR_IN(pa), .PWDATA_IN(pwd), .PRDATA_OUT(pr),
        .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .IRQ_OUT(irq));
    adcpc_host i_host (.clk(clk), .pol(pol), .sclk(sclk),
        .sync_n(sync_n), .din(din), .dout(dout));
    // ========================================
    // Clocks: 40 MHz core, 4 MHz master clock
    always #12.5 clk = ~clk;
    always @(posedge clk) begin
        mc <= (mc == 4) ? 0 : mc + 1;
        if (mc == 4) begin
            mclk <= ~mclk;
        end
    end
    // ========================================
    // Checking and closing
    task automatic complete_run();
        $display("errors %0d checks %0d", err_total, check_count);
        if (err_total == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] x,
                       input logic [31:0] g);
        check_count++;
        if (g !== x) begin
            err_total++;
            $display("FAIL %s exp %h got %h", n, x, g);
        end
    endtask
    // Bounded wait so a stuck busy ends the run
    task automatic wait_b(input logic v);
        int n;
        n = 0;
        while (busy !== v && n < 3000) begin
            @(posedge clk);
            n++;
        end
        wn = n;
        if (n >= 3000) begin
            err_total++;
            complete_run();
        end
    endtask
    // APB cycle: hold request until pready seen high at an edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        r = pr;
        e = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        if (n >= 50) begin
            err_total++;
            complete_run();
        end
    endtask
    // ========================================
    // Main sequence
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        wait_b(1'b1);
        wait_b(1'b0);
        chk("pin_dirs", 3'h7, {sclk_oe, din_oe, sync_oe});
        apb(1'b1, A_IRQ_MASK, 32'h1);
        i_host.frame({TGT_CTRL, 14'h0000}, r16);
        for (i = 0; i < 4; i++) begin
            code <= 12'($random(seed));
            rng <= i[0];
            pol <= i[1];
            slp_n <= ~i[0];
            trig <= 1'b0;
            wait_b(1'b1);
            trig <= 1'b1;
            repeat (5) @(posedge clk);
            chk("hold", 1, hold);
            chk("pwrdn", 0, pwrdn);
            wait_b(1'b0);
            // Master clock period is 10 core cycles; wait began 5 edges in
            chk("conv_len", CONV_MCLK_CYCLES, (wn + 10) / 10);
            repeat (2) @(posedge clk);
            chk("hold", 0, hold);
            chk("irq", 1, irq);
            chk("range", rng, bip);
            apb(1'b1, A_IRQ_STAT, 32'h1);
            repeat (2) @(posedge clk);
            chk("irq", 0, irq);
            apb(1'b0, A_RESULT, 32'h0);
            chk("result", code, r);
            i_host.frame(16'h0000, r16);
            chk("frame", {4'h0, code}, r16);
        end
        apb(1'b0, 8'h20, 32'h0);
        chk("slverr", 1, e);
        slp_n <= 1'b0;
        repeat (5) @(posedge clk);
        chk("pwrdn", 1, pwrdn);
        slp_n <= 1'b1;
        trig <= 1'b0;
        wait_b(1'b1);
        cal_n <= 1'b0;
        repeat (5) @(posedge clk);
        chk("abort", 0, busy);
        trig <= 1'b1;
        cal_n <= 1'b1;
        wait_b(1'b1);
        wait_b(1'b0);
        // Self-clocked modes 10 then 11: frame opens at conversion end
        for (i = 0; i < 2; i++) begin
            sma <= 1'b1;
            smb <= i[0];
            trig <= 1'b0;
            wait_b(1'b1);
            trig <= 1'b1;
            wait_b(1'b0);
            // First clock toggle comes 4 edges after the frame opens
            repeat (2) @(posedge clk);
            chk("sync_out", 0, sync_o);
            chk("sclk_out", pol, sclk_o);
            chk("din_out", 0, din_o);
            chk("pin_dirs", {1'b0, ~i[0], 1'b0},
                {sclk_oe, din_oe, sync_oe});
            // 16 bits of 8 core cycles each, then frame sync released
            repeat (140) @(posedge clk);
            chk("sync_out", 1, sync_o);
        end
        complete_run();
    end
endmodule
